// ==== charger_safety_limit_timer_regs_test.sv ====
`default_nettype none

module charger_safety_limit_timer_regs_test;
    timeunit 1ns;
    timeprecision 100ps;
    import chgl_pkg::*;

    // Short second so the safety timer fits in the run
    localparam int unsigned SEC = 4;
    localparam int T27 = 1620 * SEC;
    logic sys_clk, rst, bat_short, charging, therm_reg, input_overvoltage_protect, dpm_active, cd_high;
    logic reg_wr, reg_rd, low_chg, thermistor_sense_disable, locked, expired;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] therm_fault, dpm_code;
    logic [5:0] chg_volt, eff_volt;
    logic [3:0] fast_chg, eff_fast;
    logic [31:0] seed = 32'hD47A2CBB;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [7:0] m_lim, m_r5, m_r7;
    bit m_lock, m_short;

    chgl_regs #(.SEC_CYC(SEC)) dut (
        .SYS_CLK_I(sys_clk), .RST_I(rst), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd),
        .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_RDATA_O(reg_rdata),
        .BAT_SHORT_I(bat_short), .CHARGING_I(charging), .THERM_REG_I(therm_reg),
        .INPUT_OVERVOLTAGE_PROTECT_I(input_overvoltage_protect), .DPM_ACTIVE_I(dpm_active), .CD_HIGH_I(cd_high),
        .THERM_FAULT_I(therm_fault), .CHG_VOLT_CODE_I(chg_volt), .FAST_CHG_CODE_I(fast_chg),
        .EFF_CHG_VOLT_CODE_O(eff_volt), .EFF_FAST_CHG_CODE_O(eff_fast),
        .DPM_THRESH_CODE_O(dpm_code), .LOW_CHG_O(low_chg), .TS_ENABLE_O(thermistor_sense_disable),
        .LIMIT_LOCKED_O(locked), .TIMER_EXPIRED_O(expired)
    );

    chgl_host host (
        .clk_i(sys_clk), .wr_o(reg_wr), .rd_o(reg_rd), .addr_o(reg_addr),
        .wdata_o(reg_wdata), .rdata_i(reg_rdata)
    );

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Write through the host and keep the model in step
    task automatic mwr(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d);
        if (a == ADDR_SAFETY_LIM) begin
            if (!m_short && !m_lock) m_lim = d;
        end else if (!m_short) begin
            m_lock = 1'b1;
        end
        if (a == ADDR_DPM_TIMER) m_r5 = d;
        if (a == ADDR_NTC_TIMER) m_r7 = d;
        chk("locked", {7'h0, locked}, {7'h0, m_lock});
    endtask : mwr

    // Read back; status bits are live pins, unmapped reads give zero
    task automatic mrd(input logic [7:0] a);
        logic [7:0] v, e;
        host.rd(a, v);
        e = 8'h00;
        if (a == ADDR_DPM_TIMER) e = {m_r5[7:5], dpm_active, cd_high, m_r5[2:0]};
        if (a == ADDR_SAFETY_LIM) e = m_lim;
        if (a == ADDR_NTC_TIMER) e = {m_r7[7:3], therm_fault};
        chk("rdata", v, e);
        chk("dpm code", {5'h0, dpm_code}, {5'h0, m_r5[2:0]});
        chk("low chg", {7'h0, low_chg}, {7'h0, m_r5[5]});
        chk("ts enable", {7'h0, thermistor_sense_disable}, {7'h0, ~m_r7[3]});
    endtask : mrd

    // Random settings against the capped model; voltage cap saturates at 4.44 V
    task automatic effchk();
        int vc, ev, ef;
        chg_volt = 6'(rnd());
        fast_chg = 4'(rnd());
        repeat (3) @(posedge sys_clk);
        #1;
        vc = 35 + ((m_lim[3:0] > 12) ? 12 : m_lim[3:0]);
        ev = (chg_volt > vc) ? vc : chg_volt;
        ef = (fast_chg > m_lim[7:4]) ? m_lim[7:4] : fast_chg;
        chk("eff volt", {2'h0, eff_volt}, 8'(ev));
        chk("eff fast", {4'h0, eff_fast}, 8'(ef));
    endtask : effchk

    // Comparator level; the limit register returns to default on assertion
    task automatic short_set(input bit on);
        bat_short = on;
        repeat (on ? 5 : 3) @(posedge sys_clk);
        #1;
        m_short = on;
        if (on) begin
            m_lim = SAFETY_LIM_RESET;
            m_lock = 1'b0;
        end
    endtask : short_set

    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    // 200 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Watchdog well past the longest timer wait
    initial begin
        #(70000 * 5);
        n_mismatch++;
        conclude();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {rst, bat_short, charging, therm_reg, input_overvoltage_protect, dpm_active, cd_high} = 7'h7F;
        {charging, therm_reg, input_overvoltage_protect} = 3'h0;
        therm_fault = 3'h2;
        chg_volt = 6'h3F;
        fast_chg = 4'hF;
        {m_lim, m_r5, m_r7, m_lock, m_short} =
            {SAFETY_LIM_RESET, DPM_TIMER_RESET, NTC_TIMER_RESET, 2'b01};
        repeat (10) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        short_set(1'b0);
        mrd(ADDR_SAFETY_LIM);
        mrd(ADDR_DPM_TIMER);
        mrd(ADDR_NTC_TIMER);
        mrd(8'h3C);
        effchk();
        short_set(1'b1);
        mwr(ADDR_SAFETY_LIM, 8'(rnd()));
        mrd(ADDR_SAFETY_LIM);
        short_set(1'b0);
        // repeated writes, then lock by another register
        for (int i = 0; i < 4; i++) begin
            mwr(ADDR_SAFETY_LIM, (i == 0) ? 8'hFF : 8'(rnd()));
            mrd(ADDR_SAFETY_LIM);
            effchk();
        end
        effchk();
        mwr(ADDR_NTC_TIMER, {5'(rnd()), 3'h5});
        mwr(ADDR_SAFETY_LIM, 8'h00);
        mrd(ADDR_SAFETY_LIM);
        mrd(ADDR_NTC_TIMER);
        effchk();
        short_set(1'b1);
        short_set(1'b0);
        mwr(ADDR_DPM_TIMER, 8'(rnd()));
        mwr(ADDR_SAFETY_LIM, 8'h0F);
        mrd(ADDR_SAFETY_LIM);
        effchk();
        for (int i = 0; i < 8; i++) begin
            therm_fault = 3'(i);
            {dpm_active, cd_high} = 2'(rnd());
            repeat (3) @(posedge sys_clk);
            mrd(ADDR_NTC_TIMER);
            mrd(ADDR_DPM_TIMER);
        end
        // shortest limit expires, disable clears; clear bit never slows
        mwr(ADDR_NTC_TIMER, 8'h00);
        {input_overvoltage_protect, therm_reg} = 2'b11;
        charging = 1'b1;
        repeat (T27 - 20) @(posedge sys_clk);
        #1;
        chk("expired", {7'h0, expired}, 8'h00);
        repeat (40) @(posedge sys_clk);
        #1;
        chk("expired", {7'h0, expired}, 8'h01);
        mwr(ADDR_NTC_TIMER, 8'h60);
        repeat (4) @(posedge sys_clk);
        #1;
        chk("expired", {7'h0, expired}, 8'h00);
        charging = 1'b0;
        mwr(ADDR_NTC_TIMER, 8'h80);
        {input_overvoltage_protect, therm_reg} = 2'b01;
        charging = 1'b1;
        repeat (T27 + 40) @(posedge sys_clk);
        #1;
        chk("expired", {7'h0, expired}, 8'h00);
        repeat (T27) @(posedge sys_clk);
        #1;
        chk("expired", {7'h0, expired}, 8'h01);
        charging = 1'b0;
        mwr(ADDR_NTC_TIMER, 8'h80);
        {input_overvoltage_protect, therm_reg} = 2'b10;
        charging = 1'b1;
        repeat (T27 + 40) @(posedge sys_clk);
        #1;
        chk("expired", {7'h0, expired}, 8'h00);
        repeat (T27) @(posedge sys_clk);
        #1;
        chk("expired", {7'h0, expired}, 8'h01);
        // longer limits outlast the short one
        {input_overvoltage_protect, therm_reg} = 2'b00;
        for (int s = 1; s < 3; s++) begin
            charging = 1'b0;
            mwr(ADDR_NTC_TIMER, {1'b0, 2'(s), 5'h0});
            charging = 1'b1;
            repeat (T27 + 40) @(posedge sys_clk);
            #1;
            chk("expired", {7'h0, expired}, 8'h00);
        end
        conclude();
    end

endmodule : charger_safety_limit_timer_regs_test

`default_nettype wire

// ==== chgl_clamp.sv ====
`default_nettype none

// Passes the setting through unless it lies above the cap
module chgl_clamp #(
    parameter int W = 6
) (
    // Operands
    input wire logic [W-1:0] value_i,
    input wire logic [W-1:0] cap_i,
    // Result
    output logic [W-1:0] out_o
);

    // Both operands share base and step, so a plain compare suffices
    assign out_o = (value_i > cap_i) ? cap_i : value_i;

endmodule : chgl_clamp

`default_nettype wire

// ==== chgl_host.sv ====
`default_nettype none

// Host side of the byte register port, one strobe per byte
module chgl_host (
    // Clock
    input wire logic clk_i,
    // Register cycles
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    input wire logic [7:0] rdata_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus at time zero
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'hFF;
        wdata_o = 8'hA5;
    end

    // Released lines flip so a stale copy is never mistaken for a request
    task automatic park();
        addr_o = ~addr_o;
        wdata_o = ~wdata_o;
    endtask : park

    // One byte write, taken at the first edge with the strobe high
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = d;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        park();
    endtask : wr

    // One byte read, data sampled one edge after the strobe is taken
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        rd_o = 1'b1;
        addr_o = a;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        park();
        @(posedge clk_i);
        #1;
        d = rdata_i;
    endtask : rd

endmodule : chgl_host

`default_nettype wire

// ==== chgl_pkg.sv ====
`default_nettype none

package chgl_pkg;

    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [7:0] ADDR_DPM_TIMER = 8'h05;
    localparam logic [7:0] ADDR_SAFETY_LIM = 8'h06;
    localparam logic [7:0] ADDR_NTC_TIMER = 8'h07;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] SAFETY_LIM_RESET = 8'h50;
    localparam logic [7:0] DPM_TIMER_RESET = 8'h07;
    localparam logic [7:0] NTC_TIMER_RESET = 8'h80;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int LIM_CUR_MSB = 7;
    localparam int LIM_CUR_LSB = 4;
    localparam int LIM_VOLT_MSB = 3;
    localparam int LIM_VOLT_LSB = 0;
    localparam int NTC_HALF_BIT = 7;
    localparam int NTC_SEL_MSB = 6;
    localparam int NTC_SEL_LSB = 5;
    localparam int NTC_TS_DIS_BIT = 3;
    localparam int NTC_STORE_LSB = 3;
    localparam int DPM_LOW_CHG_BIT = 5;
    localparam int DPM_STAT_BIT = 4;
    localparam int DPM_CD_BIT = 3;
    localparam int DPM_CODE_MSB = 2;

    // Synchroniser lanes for pin inputs
    localparam int SY_SHORT = 0;
    localparam int SY_CHG = 1;
    localparam int SY_THERM = 2;
    localparam int SY_VINH = 3;
    localparam int SY_DPM = 4;
    localparam int SY_CD = 5;
    localparam int SY_FAULT_LSB = 6;
    localparam int SY_W = 9;

    // ************************************************************
    // Analog scaling, in mV and uV
    // ************************************************************
    localparam int CHG_VOLT_BASE_MV = 3500;
    localparam int LIM_VOLT_BASE_MV = 4200;
    localparam int LIM_VOLT_MAX_MV = 4440;
    localparam int VOLT_STEP_MV = 20;
    localparam int CHG_SENSE_BASE_UV = 37400;
    localparam int LIM_SENSE_BASE_UV = 37400;
    localparam int CUR_STEP_UV = 6800;
    localparam int DPM_BASE_MV = 4150;
    localparam int DPM_STEP_MV = 80;
    localparam logic [5:0] VOLT_LIM_OFFSET =
        6'((LIM_VOLT_BASE_MV - CHG_VOLT_BASE_MV) / VOLT_STEP_MV);
    localparam logic [3:0] LIM_VOLT_FIELD_MAX =
        4'((LIM_VOLT_MAX_MV - LIM_VOLT_BASE_MV) / VOLT_STEP_MV);
    localparam logic [3:0] CUR_LIM_OFFSET =
        4'((LIM_SENSE_BASE_UV - CHG_SENSE_BASE_UV) / CUR_STEP_UV);

    // ************************************************************
    // Safety timer
    // ************************************************************
    typedef enum logic [1:0] {
        TMR_27MIN = 2'b00,
        TMR_3H = 2'b01,
        TMR_6H = 2'b10,
        TMR_OFF = 2'b11
    } chgl_timer_sel_t;

    localparam int TMR_SHORT_MIN = 27;
    localparam int TMR_MID_H = 3;
    localparam int TMR_LONG_H = 6;
    localparam logic [14:0] TMR_SHORT_S = 15'(TMR_SHORT_MIN * 60);
    localparam logic [14:0] TMR_MID_S = 15'(TMR_MID_H * 3600);
    localparam logic [14:0] TMR_LONG_S = 15'(TMR_LONG_H * 3600);
    localparam int CLK_PERIOD_NS = 5;
    localparam int NS_PER_S = 1000000000;
    localparam int unsigned SEC_CYCLES = NS_PER_S / CLK_PERIOD_NS;

    // ************************************************************
    // Thermistor fault codes
    // ************************************************************
    localparam logic [2:0] TS_COLD_HOT = 3'h0;
    localparam logic [2:0] TS_NORMAL = 3'h2;
    localparam logic [2:0] TS_WARM = 3'h3;

endpackage : chgl_pkg

`default_nettype wire

// ==== chgl_regs.sv ====
`default_nettype none

// Operation
// - The current limit field is bits 7:4 weighted 54.4/27.2/13.6/6.8 mV and resets to 0101.
// - The voltage limit field is bits 3:0 weighted 160/80/40/20 mV and resets to zero.
// - The voltage limit is 4.2 V plus the field, never above 4.44 V.
// - The current limit is 550 mA plus the field with 68 mOhm, 1.05 A default, 2.05 A top.
// - Only the battery-short comparator returns the limit register to its default.
// - While battery-short holds, limit writes are ignored and defaults kept.
// - After battery-short releases, limits take any number of writes until another write locks.
// - A write elsewhere before the limit register locks in the defaults.
// - Charge voltage and fast-charge current settings cannot take effect above the limits.
// - With the half-speed bit set the safety timer runs at half rate in thermal or input-high.
// - Timer select 00/01/10/11 gives 27 min, 3 h, 6 h or timer off, default 00.
// - Bit 3 of the monitor register set disables thermistor sensing, default enabled.
// - The read-only fault code reports cold/hot, normal, warm or open sensor.
// - The input power threshold is 4.15 V plus the field, 4.71 V at reset.
// - The charge voltage setting is 3.5 V plus six bits in 20 mV steps.
// - The fast-charge setting is 37.4 mV plus four bits of 54.4 down to 6.8 mV.
module chgl_regs
    import chgl_pkg::*;
#(
    parameter int unsigned SEC_CYC = SEC_CYCLES
) (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // Register access from the serial interface byte engine
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    output logic [7:0] REG_RDATA_O,
    // Analog status pins
    input wire logic BAT_SHORT_I,
    input wire logic CHARGING_I,
    input wire logic THERM_REG_I,
    input wire logic INPUT_OVERVOLTAGE_PROTECT_I,
    input wire logic DPM_ACTIVE_I,
    input wire logic CD_HIGH_I,
    input wire logic [2:0] THERM_FAULT_I,
    // Settings held in other registers
    input wire logic [5:0] CHG_VOLT_CODE_I,
    input wire logic [3:0] FAST_CHG_CODE_I,
    // Effective settings and controls
    output logic [5:0] EFF_CHG_VOLT_CODE_O,
    output logic [3:0] EFF_FAST_CHG_CODE_O,
    output logic [2:0] DPM_THRESH_CODE_O,
    output logic LOW_CHG_O,
    output logic TS_ENABLE_O,
    output logic LIMIT_LOCKED_O,
    output logic TIMER_EXPIRED_O
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [SY_W-1:0] sync1;
        logic [SY_W-1:0] sync2;
        logic [7:0] lim;
        logic lock;
        logic [7:0] dpm_reg;
        logic [7:0] ntc_reg;
        logic [14:0] secs;
        logic expired;
        logic [7:0] rdata;
        logic [5:0] eff_v;
        logic [3:0] eff_i;
        logic thermistor_sense_disable;
        logic [2:0] fault_prev;
        logic [2:0] fault_hold;
    } chgl_state_t;

    chgl_state_t st;
    chgl_state_t next_st;

    logic [SY_W-1:0] pins;
    logic short_s;
    logic chg_s;
    logic slow;
    logic run;
    logic tick;
    logic [2:0] fault_s;
    logic [3:0] vlim;
    logic [5:0] volt_cap;
    logic [3:0] cur_cap;
    logic [5:0] volt_eff;
    logic [3:0] cur_eff;
    logic [14:0] limit_secs;
    chgl_timer_sel_t tsel;

    // Raw pin levels, lane order set by the lane numbers
    assign pins = {THERM_FAULT_I, CD_HIGH_I, DPM_ACTIVE_I, INPUT_OVERVOLTAGE_PROTECT_I,
                   THERM_REG_I, CHARGING_I, BAT_SHORT_I};

    // Synchronised pin levels, taken from the second stage only
    assign short_s = st.sync2[SY_SHORT];
    assign chg_s = st.sync2[SY_CHG];
    assign fault_s = st.sync2[SY_FAULT_LSB +: 3];
    assign tsel = chgl_timer_sel_t'(st.ntc_reg[NTC_SEL_MSB:NTC_SEL_LSB]);

    // ************************************************************
    // Limit caps
    // ************************************************************
    // voltage field, low nibble
    // field saturates at the 4.44 V option
    assign vlim = (st.lim[LIM_VOLT_MSB:LIM_VOLT_LSB] > LIM_VOLT_FIELD_MAX) ?
                  LIM_VOLT_FIELD_MAX : st.lim[LIM_VOLT_MSB:LIM_VOLT_LSB];
    // voltage cap in 3.5 V based 20 mV steps
    assign volt_cap = VOLT_LIM_OFFSET + {2'b00, vlim};
    // both current codes sit on a 37.4 mV base
    assign cur_cap = st.lim[LIM_CUR_MSB:LIM_CUR_LSB] + CUR_LIM_OFFSET;

    chgl_clamp #(
        .W(6)
    ) u_volt_clamp (
        .value_i(CHG_VOLT_CODE_I),
        .cap_i(volt_cap),
        .out_o(volt_eff)
    );

    chgl_clamp #(
        .W(4)
    ) u_cur_clamp (
        .value_i(FAST_CHG_CODE_I),
        .cap_i(cur_cap),
        .out_o(cur_eff)
    );

    // ************************************************************
    // Safety timer
    // ************************************************************
    // slow only when enabled and regulating
    assign slow = st.ntc_reg[NTC_HALF_BIT] &&
                  (st.sync2[SY_THERM] || st.sync2[SY_VINH]);
    assign run = chg_s && (tsel != TMR_OFF) && !st.expired;

    chgl_tick #(
        .CYC(SEC_CYC)
    ) u_tick (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .run_i(run),
        .slow_i(slow),
        .tick_o(tick)
    );

    // fast-charge limit from the select field
    always_comb begin
        case (tsel)
            TMR_27MIN: limit_secs = TMR_SHORT_S;
            TMR_3H: limit_secs = TMR_MID_S;
            TMR_6H: limit_secs = TMR_LONG_S;
            default: limit_secs = '1;
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_st = st;
        next_st.sync1 = pins;
        next_st.sync2 = st.sync1;
        // fault code is a word; taken once two samples agree
        next_st.fault_prev = fault_s;
        if (st.fault_prev == fault_s) begin
            next_st.fault_hold = fault_s;
        end

        // Limit register and its lock
        if (short_s) begin
            // only the short comparator restores defaults
            next_st.lim = SAFETY_LIM_RESET;
            next_st.lock = 1'b0;
        end else if (REG_WR_I) begin
            if (REG_ADDR_I == ADDR_SAFETY_LIM) begin
                if (!st.lock) begin
                    next_st.lim = REG_WDATA_I;
                end
            end else begin
                // any other write freezes the limits
                next_st.lock = 1'b1;
            end
        end

        // Ordinary registers, written regardless of the lock
        if (REG_WR_I && REG_ADDR_I == ADDR_DPM_TIMER) begin
            // threshold field stored with the rest
            next_st.dpm_reg = REG_WDATA_I;
        end
        if (REG_WR_I && REG_ADDR_I == ADDR_NTC_TIMER) begin
            // Low bits are the read-only fault code
            next_st.ntc_reg = {REG_WDATA_I[7:NTC_STORE_LSB], 3'h0};
        end

        if (!chg_s || tsel == TMR_OFF) begin
            next_st.secs = '0;
            next_st.expired = 1'b0;
        end else if (tick) begin
            if (st.secs + 15'h0001 >= limit_secs) begin
                next_st.expired = 1'b1;
            end else begin
                next_st.secs = st.secs + 15'h0001;
            end
        end

        // Read data, status bits live
        if (REG_RD_I) begin
            case (REG_ADDR_I)
                ADDR_DPM_TIMER: next_st.rdata = {st.dpm_reg[7:DPM_STAT_BIT + 1],
                                                 st.sync2[SY_DPM], st.sync2[SY_CD],
                                                 st.dpm_reg[DPM_CODE_MSB:0]};
                ADDR_SAFETY_LIM: next_st.rdata = st.lim;
                // fault code from the sensor comparators
                ADDR_NTC_TIMER: next_st.rdata = {st.ntc_reg[7:NTC_STORE_LSB], st.fault_hold};
                default: next_st.rdata = RDATA_UNMAPPED;
            endcase
        end

        next_st.eff_v = volt_eff;
        next_st.eff_i = cur_eff;
        // sense enabled while the disable bit is clear
        next_st.thermistor_sense_disable = !st.ntc_reg[NTC_TS_DIS_BIT];

        // Ordinary reset leaves the limits and lock alone
        if (RST_I) begin
            next_st = '0;
            // Pins keep flowing so a short seen in reset restores the limits
            next_st.sync1 = pins;
            next_st.sync2 = st.sync1;
            next_st.lim = short_s ? SAFETY_LIM_RESET : st.lim;
            next_st.lock = short_s ? 1'b0 : st.lock;
            next_st.dpm_reg = DPM_TIMER_RESET;
            next_st.ntc_reg = NTC_TIMER_RESET;
            next_st.thermistor_sense_disable = 1'b1;
        end
    end

    // State register; reset is folded into the next-state logic
    always_ff @(posedge SYS_CLK_I) begin
        st <= next_st;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign REG_RDATA_O = st.rdata;
    assign EFF_CHG_VOLT_CODE_O = st.eff_v;
    assign EFF_FAST_CHG_CODE_O = st.eff_i;
    assign DPM_THRESH_CODE_O = st.dpm_reg[DPM_CODE_MSB:0];
    assign LOW_CHG_O = st.dpm_reg[DPM_LOW_CHG_BIT];
    assign TS_ENABLE_O = st.thermistor_sense_disable;
    assign LIMIT_LOCKED_O = st.lock;
    assign TIMER_EXPIRED_O = st.expired;

    // ************************************************************
    // Checks
    // ************************************************************
    // short restores defaults
    a_short_default: assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        short_s |=> (st.lim == SAFETY_LIM_RESET) && !LIMIT_LOCKED_O)
        else $error("limits not default after short");

    a_short_wr_ignored: assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        (short_s && REG_WR_I && REG_ADDR_I == ADDR_SAFETY_LIM) |=>
        (st.lim == SAFETY_LIM_RESET))
        else $error("limit write taken during short");

    a_limit_wr_taken: assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        (!short_s && !st.lock && REG_WR_I && REG_ADDR_I == ADDR_SAFETY_LIM)
        |=> (st.lim == $past(REG_WDATA_I)))
        else $error("unlocked limit write lost");

    a_locked_stable: assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        (st.lock && !short_s) |=> $stable(st.lim))
        else $error("locked limits changed");

    a_other_locks: assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        (!short_s && REG_WR_I && REG_ADDR_I != ADDR_SAFETY_LIM) |=> LIMIT_LOCKED_O)
        else $error("other write failed to lock limits");

    a_volt_capped: assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        1'b1 |=> (EFF_CHG_VOLT_CODE_O <= $past(volt_cap)) &&
        (EFF_CHG_VOLT_CODE_O == $past(CHG_VOLT_CODE_I) ||
         EFF_CHG_VOLT_CODE_O == $past(volt_cap)))
        else $error("voltage setting escaped its cap");

    a_cur_capped: assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        (FAST_CHG_CODE_I > cur_cap) |=> (EFF_FAST_CHG_CODE_O == $past(cur_cap)))
        else $error("current setting escaped its cap");

    a_timer_off: assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        (tsel == TMR_OFF) |=> !TIMER_EXPIRED_O)
        else $error("expiry while timer disabled");

    a_ts_follow: assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        (REG_WR_I && REG_ADDR_I == ADDR_NTC_TIMER) |=> ##1
        (TS_ENABLE_O == !$past(REG_WDATA_I[NTC_TS_DIS_BIT], 2)))
        else $error("sense enable wrong after write");

endmodule : chgl_regs

`default_nettype wire

// ==== chgl_tick.sv ====
`default_nettype none

// One-second tick for the safety timer, optionally at half rate
module chgl_tick #(
    parameter int unsigned CYC = 200000000
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic run_i,
    input wire logic slow_i,
    // Tick pulse
    output logic tick_o
);

    localparam int CW = $clog2(CYC);
    localparam logic [CW-1:0] LAST = CW'(CYC - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic odd;
        logic tick;
    } chgl_tick_t;

    chgl_tick_t st;
    chgl_tick_t next_st;

    // Prescaler; a slowed second swallows every other wrap
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (!run_i) begin
            next_st.cnt = '0;
            next_st.odd = 1'b0;
        end else if (st.cnt == LAST) begin
            next_st.cnt = '0;
            if (slow_i && !st.odd) begin
                next_st.odd = 1'b1;
            end else begin
                next_st.odd = 1'b0;
                next_st.tick = 1'b1;
            end
        end else begin
            next_st.cnt = st.cnt + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;

    a_half_speed_skip: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (run_i && slow_i && st.cnt == LAST && !st.odd) |=> !tick_o)
        else $error("slowed timer ticked on the first wrap");

endmodule : chgl_tick

`default_nettype wire
